// ### rdf_framer.v
// transmit framing control: rate divider, frame sequencing, buffer and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "rdf_map.vh"

module rdf_framer #(
	parameter BUF_BYTES = 32,
	parameter ACC_W = 20
)(
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// axi4-lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// rf output stage
	output reg tx_data_q,
	output reg tx_on_q,
	output reg [`RDF_PWR_W-1:0] output_power_step,
	input wire lock_fail,
	input wire osc_fail,
	// interrupt
	output wire irq
);

	localparam ST_IDLE = 2'd0;
	localparam ST_DATA = 2'd1;
	localparam ST_TRAIL = 2'd2;
	localparam ST_STOP = 2'd3;

	// buffer byte index from page and window address
	function [4:0] buf_idx;
		input page;
		input [7:0] addr;
		begin
			buf_idx = {page, addr[5:2]};
		end
	endfunction

	// register state
	reg [7:0] bit_rate_divider_q;
	reg [7:0] frame_length_q;
	reg [3:0] frame_count_q;
	reg buffer_page_select_q;
	reg trailer_bits_enable_q;
	reg send_q;
	reg [1:0] stat_q;
	reg [1:0] ien_q;
	reg [7:0] bank_q [0:7];
	reg [7:0] buf_mem [0:BUF_BYTES-1];

	// sequencer state
	reg [1:0] state_q;
	reg [7:0] bit_idx_q;
	reg [3:0] frame_idx_q;
	reg [1:0] trail_cnt_q;
	reg [ACC_W-1:0] acc_q;

	// fault pin synchronisers
	reg [1:0] flt_s1_q;
	reg [1:0] flt_s2_q;

	// axi handshake state
	reg aw_have_q;
	reg w_have_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	integer i;

	// fault pins come from the analog side; two flops before any logic
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			flt_s1_q <= 2'b00;
			flt_s2_q <= 2'b00;
		end
		else
		begin
			flt_s1_q <= {osc_fail, lock_fail};
			flt_s2_q <= flt_s1_q;
		end
	end

	// write channels are taken in either order, response waits for both
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire aw_ok = s_axi_awvalid && s_axi_awready;
	wire w_ok = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	wire wr_lane = w_strb_q[0];
	wire [7:0] wd = w_data_q[7:0];
	wire wr_buf = aw_addr_q[7:6] == 2'b01;
	wire wr_bank = aw_addr_q[7:4] == 4'h2;

	// decode of a committed write
	wire wr_map = wr_buf || wr_bank || (aw_addr_q[7:5] == 3'b000);
	wire wr_rate = wr_fire && wr_lane && aw_addr_q == `RDF_A_RATE;
	wire wr_flen = wr_fire && wr_lane && aw_addr_q == `RDF_A_FLEN;
	wire wr_tctl = wr_fire && wr_lane && aw_addr_q == `RDF_A_TCTL;
	wire wr_fcnt = wr_fire && wr_lane && aw_addr_q == `RDF_A_FCNT;
	wire wr_ien = wr_fire && wr_lane && aw_addr_q == `RDF_A_IEN;
	wire wr_iclr = wr_fire && wr_lane && aw_addr_q == `RDF_A_ICLR;
	wire mod_rst = wr_fire && wr_lane && aw_addr_q == `RDF_A_MRST && wd[0];

	// bit period in system clocks scaled by crystal rate, fractional accumulator
	// sums are formed at 32 bits and cut on purpose; the largest period fits well inside ACC_W
	wire [31:0] period_w = `RDF_SYS_MHZ * `RDF_RATE_MULT * ({24'h00_0000, bit_rate_divider_q}
		+ 32'h0000_0001);
	wire [31:0] acc_w = {{(32-ACC_W){1'b0}}, acc_q} + `RDF_XTAL_MHZ;
	wire [ACC_W-1:0] period = period_w[ACC_W-1:0];
	wire [ACC_W-1:0] acc_nx = acc_w[ACC_W-1:0];
	wire tick = acc_nx >= period;

	// buffer bit under the pointer, ascending order
	wire cur_bit = buf_mem[bit_idx_q[7:3]][bit_idx_q[2:0]];

	wire busy = state_q != ST_IDLE;
	wire fault = flt_s2_q[0] || flt_s2_q[1];
	wire start = wr_tctl && wd[`RDF_B_SEND] && !busy && frame_length_q != 8'h00;
	wire abort_sw = wr_tctl && !wd[`RDF_B_SEND] && busy;
	wire abort_flt = busy && fault;
	wire finish = state_q == ST_STOP && tick;

	// interrupt level from enabled sticky events
	assign irq = |(stat_q & ien_q);

	// registers steered by software, module reset leaves page and buffer alone
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			bit_rate_divider_q <= `RDF_RATE_RST;
			frame_length_q <= `RDF_FLEN_RST;
			frame_count_q <= `RDF_FCNT_RST;
			buffer_page_select_q <= 1'b0;
			trailer_bits_enable_q <= 1'b0;
			output_power_step <= `RDF_PWR_RST;
			ien_q <= 2'b00;
		end
		else if (mod_rst)
		begin
			bit_rate_divider_q <= `RDF_RATE_RST;
			frame_length_q <= `RDF_FLEN_RST;
			frame_count_q <= `RDF_FCNT_RST;
			trailer_bits_enable_q <= 1'b0;
			output_power_step <= `RDF_PWR_RST;
		end
		else
		begin
			if (wr_rate)
				bit_rate_divider_q <= wd;
			if (wr_flen)
				frame_length_q <= wd;
			if (wr_fcnt)
				frame_count_q <= wd[3:0];
			if (wr_ien)
				ien_q <= wd[1:0];
			if (wr_tctl)
			begin
				buffer_page_select_q <= wd[`RDF_B_PAGE];
				trailer_bits_enable_q <= wd[`RDF_B_TRAIL];
				output_power_step <= wd[`RDF_PWR_W-1:0];
			end
		end
	end

	// sticky events; a new event in the clearing cycle survives
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			stat_q <= 2'b00;
		else
		begin
			stat_q[`RDF_S_DONE] <= finish
				|| (stat_q[`RDF_S_DONE] && !(wr_iclr && wd[`RDF_S_DONE]));
			stat_q[`RDF_S_ERR] <= abort_flt
				|| (stat_q[`RDF_S_ERR] && !(wr_iclr && wd[`RDF_S_ERR]));
		end
	end

	// buffer and banked registers keep their contents over a module reset
	always @(posedge clk_sys)
	begin
		if (wr_fire && wr_lane && wr_buf)
			buf_mem[buf_idx(buffer_page_select_q, aw_addr_q)] <= wd;
		if (wr_fire && wr_lane && wr_bank)
			bank_q[{buffer_page_select_q, aw_addr_q[3:2]}] <= wd;
	end

	// frame sequencer: one bit per tick, frames back to back, optional trailer
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			send_q <= 1'b0;
			bit_idx_q <= 8'h00;
			frame_idx_q <= 4'h0;
			trail_cnt_q <= 2'b00;
			acc_q <= {ACC_W{1'b0}};
			tx_data_q <= 1'b0;
			tx_on_q <= 1'b0;
		end
		else if (mod_rst || abort_sw || abort_flt || finish)
		begin
			state_q <= ST_IDLE;
			send_q <= 1'b0;
			tx_on_q <= 1'b0;
			tx_data_q <= 1'b0;
		end
		else if (start)
		begin
			state_q <= ST_DATA;
			send_q <= 1'b1;
			tx_on_q <= 1'b1;
			bit_idx_q <= 8'h00;
			frame_idx_q <= 4'h0;
			trail_cnt_q <= 2'b00;
			acc_q <= {ACC_W{1'b0}};
		end
		else if (busy)
		begin
			acc_q <= tick ? acc_nx - period : acc_nx;
			if (tick)
			begin
				case (state_q)
					ST_DATA:
					begin
						tx_data_q <= cur_bit;
						if (bit_idx_q == frame_length_q)
						begin
							bit_idx_q <= 8'h00;
							if (frame_idx_q == frame_count_q)
								state_q <= trailer_bits_enable_q ? ST_TRAIL : ST_STOP;
							else
								frame_idx_q <= frame_idx_q + 4'h1;
						end
						else
							bit_idx_q <= bit_idx_q + 8'h01;
					end
					ST_TRAIL:
					begin
						tx_data_q <= 1'b1;
						trail_cnt_q <= trail_cnt_q + 2'b01;
						if (trail_cnt_q == `RDF_TRAIL_BITS - 2'd1)
							state_q <= ST_STOP;
					end
					default:
						state_q <= ST_STOP;
				endcase
			end
		end
	end

	// read data mux, unmapped addresses answer slave error
	reg [31:0] rd_d;
	reg rd_err;
	always @*
	begin
		rd_d = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr[7:6] == 2'b01)
			rd_d[7:0] = buf_mem[buf_idx(buffer_page_select_q, s_axi_araddr)];
		else if (s_axi_araddr[7:4] == 4'h2)
			rd_d[7:0] = bank_q[{buffer_page_select_q, s_axi_araddr[3:2]}];
		else
		begin
			case (s_axi_araddr)
				`RDF_A_RATE: rd_d[7:0] = bit_rate_divider_q;
				`RDF_A_FLEN: rd_d[7:0] = frame_length_q;
				`RDF_A_TCTL: rd_d[7:0] = {send_q, buffer_page_select_q,
					trailer_bits_enable_q, output_power_step};
				`RDF_A_FCNT: rd_d[7:0] = {4'h0, frame_count_q};
				`RDF_A_STAT: rd_d[7:0] = {6'h00, stat_q};
				`RDF_A_IEN: rd_d[7:0] = {6'h00, ien_q};
				`RDF_A_ICLR: rd_d = 32'h0000_0000;
				`RDF_A_MRST: rd_d = 32'h0000_0000;
				default: rd_err = 1'b1;
			endcase
		end
	end

	// axi write capture and response
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RDF_RESP_OK;
		end
		else
		begin
			if (aw_ok)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (w_ok)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `RDF_RESP_OK : `RDF_RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi read answer, one cycle after the address is taken
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RDF_RESP_OK;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rd_err ? `RDF_RESP_ERR : `RDF_RESP_OK;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ### rdf_map.vh
// register map, field positions, reset values and timing constants of the framer
`ifndef RDF_MAP_VH
`define RDF_MAP_VH

// register byte addresses
`define RDF_A_RATE 8'h00
`define RDF_A_FLEN 8'h04
`define RDF_A_TCTL 8'h08
`define RDF_A_FCNT 8'h0C
`define RDF_A_STAT 8'h10
`define RDF_A_IEN 8'h14
`define RDF_A_ICLR 8'h18
`define RDF_A_MRST 8'h1C
`define RDF_A_BANK 8'h20
`define RDF_A_BUF 8'h40

// transmit_control fields
`define RDF_B_SEND 7
`define RDF_B_PAGE 6
`define RDF_B_TRAIL 5
`define RDF_PWR_W 5

// status, enable and clear layout
`define RDF_S_DONE 0
`define RDF_S_ERR 1

// reset values
`define RDF_RATE_RST 8'h34
`define RDF_FLEN_RST 8'h00
`define RDF_FCNT_RST 4'h0
`define RDF_PWR_RST 5'h00

// bit rate: crystal / (52 * (code + 1)), built from the system clock
`define RDF_XTAL_MHZ 26
`define RDF_SYS_MHZ 25
`define RDF_RATE_MULT 52

// trailer length in bit times
`define RDF_TRAIL_BITS 2'd2

// axi response codes
`define RDF_RESP_OK 2'b00
`define RDF_RESP_ERR 2'b10

`endif

// ### rdf_checker.sv
// bus and serial output assertions for the framer
`timescale 1ns/100ps
`include "rdf_map.vh"
module rdf_checker (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// register bus
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// rf output stage
	input wire tx_data_q,
	input wire tx_on_q,
	input wire lock_fail,
	input wire osc_fail
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready while data pending");
	a_b_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_r_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_rdata_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1 && s_axi_bresp != 2'h3)
		else $error("write response code unknown");
	// faults stop the output one clock after the synchroniser delay
	a_fault_stop: assert property (tx_on_q && (lock_fail || osc_fail) |-> ##[1:4] !tx_on_q)
		else $error("output kept on after fault");
	a_lead_quiet: assert property ($rose(tx_on_q) |-> !tx_data_q [*8])
		else $error("data before first period");
	// shortest period is about 50 clocks, so a bit must hold far longer than 8
	a_bit_hold: assert property (tx_on_q && $changed(tx_data_q)
		|=> (!tx_on_q || $stable(tx_data_q)) [*8])
		else $error("bit shorter than a period");
endmodule

// ### rdf_stage_model.sv
// rf output stage model: samples each bit mid period, drives the fault pins on command
`timescale 1ns/100ps
module rdf_stage_model (
	input wire clk_sys,
	input wire tx_data_q,
	input wire tx_on_q,
	input wire [1:0] fault,
	input wire [15:0] per,
	output logic lock_fail,
	output logic osc_fail,
	output logic [63:0] seen,
	output logic [6:0] n_seen
);
	int cnt = 0;
	initial {lock_fail, osc_fail, seen, n_seen} = 0;
	// sampling mid period keeps clear of the one clock edge jitter
	always @(posedge clk_sys)
	begin
		lock_fail <= fault[0];
		osc_fail <= fault[1];
		cnt <= tx_on_q ? cnt + 1 : 0;
		if (tx_on_q && cnt == 0)
			n_seen <= 0;
		if (tx_on_q && cnt >= per && cnt % per == per / 2)
		begin
			seen[n_seen] <= tx_data_q;
			n_seen <= n_seen + 7'h1;
		end
	end
endmodule

// ### test_rf_datagram_framer_control.sv
// self-checking bench of the framer with an rf stage model
`timescale 1ns/100ps
`include "rdf_map.vh"
module test_rf_datagram_framer_control;
	logic clk_sys = 0, rst = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, d;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire tx_data_q, tx_on_q, lock_fail, osc_fail, irq;
	wire [4:0] output_power_step;
	wire [63:0] seen;
	wire [6:0] n_seen;
	logic [1:0] fault = 0, r;
	logic [15:0] per = 50;
	logic [7:0] bm [32];
	int n_fail = 0, checked = 0, cyc = 0, k, t, e, f, n, len;
	rdf_framer dut_u (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data_q, .tx_on_q,
		.output_power_step, .lock_fail, .osc_fail, .irq);
	rdf_stage_model stage_u (.clk_sys, .tx_data_q, .tx_on_q, .fault, .per, .lock_fail,
		.osc_fail, .seen, .n_seen);
	initial forever #20 clk_sys = ~clk_sys;
	task chk(input [31:0] s, input [31:0] x);
		checked++;
		if (s !== x)
		begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// readiness is looked at before the edge so the edge's own updates cannot race it
	task wr(input [7:0] a, input [7:0] v);
		logic ta, tw, tb;
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h00_0000, v, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		tb = 0;
		while (!tb)
		begin
			@(negedge clk_sys);
			{ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tb) s_axi_bready <= 0;
		end
	endtask
	task rd(input [7:0] a);
		logic ta, tr;
		@(posedge clk_sys);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		tr = 0;
		while (!tr)
		begin
			@(negedge clk_sys);
			{ta, tr, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 0;
			if (tr) s_axi_rready <= 0;
		end
	endtask
	task rchk(input [7:0] a, input [31:0] x);
		rd(a);
		chk(d, x);
	endtask
	task summarize();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(13));
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		rchk(`RDF_A_RATE, `RDF_RATE_RST);
		rchk(`RDF_A_FLEN, `RDF_FLEN_RST);
		rchk(`RDF_A_TCTL, 0);
		rd(8'hF0);
		chk(r, `RDF_RESP_ERR);
		wr(8'hF0, 8'h00);
		chk(r, `RDF_RESP_ERR);
		$display("reset values done");
		// fill both pages with random bytes, then read them back
		for (k = 0; k < 64; k++)
		begin
			if (k % 16 == 0) wr(`RDF_A_TCTL, 8'((k / 16 % 2) << `RDF_B_PAGE));
			if (k < 32) bm[k] = 8'($urandom);
			if (k < 32) wr(8'(`RDF_A_BUF + 4 * (k % 16)), bm[k]);
			else rchk(8'(`RDF_A_BUF + 4 * (k % 16)), bm[k % 32]);
		end
		wr(`RDF_A_BANK, 8'hA5);
		wr(`RDF_A_TCTL, 8'h00);
		wr(`RDF_A_BANK, 8'h5A);
		rchk(`RDF_A_BANK, 8'h5A);
		wr(`RDF_A_TCTL, 8'h40);
		rchk(`RDF_A_BANK, 8'hA5);
		$display("pages done");
		wr(`RDF_A_TCTL, 8'h80);
		rchk(`RDF_A_TCTL, 0);
		chk(tx_on_q, 0);
		$display("empty frame done");
		// two rates; the second has two frames and the trailer
		wr(`RDF_A_IEN, 8'h03);
		for (t = 0; t < 2; t++)
		begin
			len = 2 + $urandom % 8;
			per <= 16'(`RDF_RATE_MULT * (t + 1) * `RDF_SYS_MHZ / `RDF_XTAL_MHZ);
			wr(`RDF_A_RATE, 8'(t));
			wr(`RDF_A_FLEN, 8'(len));
			wr(`RDF_A_FCNT, 8'(t));
			wr(`RDF_A_TCTL, {1'b1, 1'b0, t[0], 5'h00});
			rchk(`RDF_A_TCTL, {1'b1, 1'b0, t[0], 5'h00});
			for (k = 0; k < 8000 && irq !== 1'b1; k++) @(posedge clk_sys);
			chk(irq, 1);
			rchk(`RDF_A_TCTL, {2'b00, t[0], 5'h00});
			rchk(`RDF_A_STAT, 1);
			e = 0;
			for (f = 0; f <= t; f++)
				for (n = 0; n <= len; n++)
				begin
					chk(seen[e], bm[n / 8][n % 8]);
					e++;
				end
			if (t == 1) chk(seen[e+:2], 2'b11);
			chk(n_seen, e + 2 * t);
			wr(`RDF_A_ICLR, 8'h01);
			chk(irq, 0);
		end
		$display("transmissions done");
		// abort by software, then a lock fault and an oscillator fault
		for (t = 0; t < 3; t++)
		begin
			wr(`RDF_A_TCTL, 8'h80);
			repeat (100) @(posedge clk_sys);
			if (t == 0) wr(`RDF_A_TCTL, 8'h00);
			else fault <= 2'(t);
			repeat (8) @(posedge clk_sys);
			fault <= 0;
			chk(tx_on_q, 0);
			rchk(`RDF_A_TCTL, 0);
			rchk(`RDF_A_STAT, t ? 2 : 0);
		end
		wr(`RDF_A_IEN, 8'h00);
		chk(irq, 0);
		wr(`RDF_A_IEN, 8'h02);
		chk(irq, 1);
		wr(`RDF_A_ICLR, 8'h02);
		chk(irq, 0);
		$display("abort and faults done");
		wr(`RDF_A_TCTL, 8'h7F);
		chk(output_power_step, 5'h1F);
		wr(`RDF_A_MRST, 8'h01);
		chk(r, `RDF_RESP_OK);
		chk(output_power_step, 5'h00);
		rchk(`RDF_A_RATE, `RDF_RATE_RST);
		rchk(`RDF_A_FLEN, 0);
		rchk(`RDF_A_TCTL, 8'h40);
		$display("module reset done");
		summarize();
	end
endmodule
bind rdf_framer rdf_checker chk_u (.clk_sys, .rst, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .tx_data_q, .tx_on_q, .lock_fail, .osc_fail);
